// ### pkg/tmr16_defines.svh
// register offsets, field codes and limits of the 16-bit timer
`ifndef TMR16_DEFINES_SVH
`define TMR16_DEFINES_SVH

// ==========================================
// byte-wide register offsets
`define TMR_OFS_CAP_LO 8'h26
`define TMR_OFS_CAP_HI 8'h27
`define TMR_OFS_CMPB_LO 8'h28
`define TMR_OFS_CMPB_HI 8'h29
`define TMR_OFS_CMPA_LO 8'h2A
`define TMR_OFS_CMPA_HI 8'h2B
`define TMR_OFS_CNT_LO 8'h2C
`define TMR_OFS_CNT_HI 8'h2D

// ==========================================
// reset values
`define TMR_RST_BYTE 8'h00
`define TMR_RST_WORD 16'h0000

// ==========================================
// pwm resolution codes and top values
`define TMR_RES_OFF 2'h0
`define TMR_RES_8 2'h1
`define TMR_RES_9 2'h2
`define TMR_TOP_8 10'h0FF
`define TMR_TOP_9 10'h1FF
`define TMR_TOP_10 10'h3FF

// ==========================================
// clock select codes
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1

// ==========================================
// compare output mode codes
`define TMR_COM_OFF 2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR 2'h2
`define TMR_COM_SET 2'h3

`endif

// ### pkg/tmr16_pkg.sv
// types shared by the 16-bit timer design
package tmr16_pkg;
	// count direction of the up/down counter
	typedef enum logic {DIR_UP, DIR_DOWN} count_dir_e;
	// one byte of the cpu register path
	typedef logic [7:0] byte_t;
endpackage

// ### core/tmr16_capture.sv
// edge-triggered capture of the count value
`timescale 1ns/100ps
`default_nettype none
`include "tmr16_defines.svh"

module tmr16_capture #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         capture_input_pin,   // sampled capture pin
	input  wire logic         capture_edge_select, // 1 rising, 0 falling
	input  wire logic [W-1:0] cnt,                 // live count
	output logic      [W-1:0] capture_register,    // captured count
	output logic              capture_flag         // one-cycle event
);

	// ==========================================
	// edge detection and capture
	logic         prev_q, prev_d;   // pin in the previous cycle
	logic         seen_q, seen_d;   // prev_q holds a real sample
	logic [W-1:0] cap_q, cap_d;     // capture value
	logic         flag_q, flag_d;   // capture event
	logic         edge_hit;

	// compare current and previous pin level
	always_comb
	begin
		edge_hit = seen_q && (capture_edge_select ? (capture_input_pin && !prev_q)
			: (!capture_input_pin && prev_q));
		prev_d = capture_input_pin;
		seen_d = 1'b1;
		cap_d = edge_hit ? cnt : cap_q;
		flag_d = edge_hit;
	end

	// registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			prev_q <= 1'b0;
			seen_q <= 1'b0;
			cap_q <= `TMR_RST_WORD;
			flag_q <= 1'b0;
		end
		else
		begin
			prev_q <= prev_d;
			seen_q <= seen_d;
			cap_q <= cap_d;
			flag_q <= flag_d;
		end
	end

	assign capture_register = cap_q;
	assign capture_flag = flag_q;

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_capture_same_cycle: assert property (edge_hit |=> capture_flag
		&& capture_register == $past(cnt))
		else $error("capture value and flag not set together");
	a_capture_rise_only: assert property ((seen_q && capture_edge_select
		&& !prev_q && capture_input_pin) |=> capture_flag)
		else $error("rising edge not captured");
	c_capture_event: cover property (capture_flag);

endmodule
`default_nettype wire

// ### core/tmr16_compare.sv
// one compare channel: value, pwm holding copy and output pin
`timescale 1ns/100ps
`default_nettype none
`include "tmr16_defines.svh"

module tmr16_compare #(
	parameter int W  = 16,
	parameter int PW = 10
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          pwm_on,      // pwm resolution selected
	input  wire logic          wr_lo,       // low-byte write strobe
	input  wire logic [W-1:0]  wr_word,     // staged high byte and low byte
	input  wire logic [W-1:0]  cnt,         // live count
	input  wire logic          counted,     // count moved by counting
	input  wire logic          moved_up,    // that move was upward
	input  wire logic          at_top,      // count just reached top
	input  wire logic [PW-1:0] top,         // current top value
	input  wire logic          div1,        // undivided clock selected
	input  wire logic [1:0]    mode,        // compare output mode
	input  wire logic          port_we,     // port bit write
	input  wire logic          port_val,    // port bit value
	output logic      [W-1:0]  read_value,  // software view
	output logic               match_flag,  // one-cycle event
	output logic               pin          // compare output
);

	// ==========================================
	// compare storage and pin state
	logic [W-1:0] hold_q, hold_d;  // last written value
	logic [W-1:0] act_q, act_d;    // value in use
	logic         pin_q, pin_d;
	logic         flag_q, flag_d;
	logic         ph_q, ph_d;      // top-match phase when prescaled
	logic         hit;

	// pwm level after a match: up gives mode bit 0, down its inverse
	function automatic logic pwm_level(input logic up, input logic [1:0] m);
		pwm_level = up ? m[0] : !m[0];
	endfunction

	// next values of storage, flag and pin
	always_comb
	begin
		hold_d = hold_q;
		act_d = act_q;
		pin_d = pin_q;
		ph_d = ph_q;
		// match only when the counter counts onto the value
		hit = counted && (pwm_on ? cnt[PW-1:0] == act_q[PW-1:0]
			: cnt == act_q);
		flag_d = hit;
		if (wr_lo)
		begin
			hold_d = wr_word;
			if (!pwm_on)
				act_d = wr_word;
			else
				act_d[W-1:PW] = wr_word[W-1:PW];
		end
		// pwm value moves in only at top
		if (pwm_on && at_top)
			act_d[PW-1:0] = hold_d[PW-1:0];
		if (hit && pwm_on && mode[1])
		begin
			if (act_q[PW-1:0] == '0)
				pin_d = pwm_level(1'b1, mode);
			else if (act_q[PW-1:0] == top && div1)
				pin_d = pwm_level(1'b0, mode);
			else if (act_q[PW-1:0] == top)
			begin
				// alternate up and down action at each top
				pin_d = pwm_level(!ph_q, mode);
				ph_d = !ph_q;
			end
			else
				pin_d = pwm_level(moved_up, mode);
		end
		else if (hit && !pwm_on)
		begin
			case (mode)
				`TMR_COM_TOGGLE: pin_d = !pin_q;
				`TMR_COM_CLEAR: pin_d = 1'b0;
				`TMR_COM_SET: pin_d = 1'b1;
				default: pin_d = pin_q;
			endcase
		end
		if (port_we)
			pin_d = port_val;
	end

	// registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			hold_q <= `TMR_RST_WORD;
			act_q <= `TMR_RST_WORD;
			pin_q <= 1'b0;
			flag_q <= 1'b0;
			ph_q <= 1'b0;
		end
		else
		begin
			hold_q <= hold_d;
			act_q <= act_d;
			pin_q <= pin_d;
			flag_q <= flag_d;
			ph_q <= ph_d;
		end
	end

	// pwm mode reads the holding copy
	assign read_value = pwm_on ? hold_q : act_q;
	assign match_flag = flag_q;
	assign pin = pin_q;

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_match_flag_delay: assert property (hit |=> match_flag)
		else $error("compare flag not set after match");
	a_no_write_match: assert property (!counted |=> !match_flag)
		else $error("match without counting");
	a_pwm_latch_top: assert property ((pwm_on && !at_top && !wr_lo)
		|=> $stable(act_q[PW-1:0]))
		else $error("pwm compare changed away from top");
	a_readback_latest: assert property (wr_lo |=> read_value == $past(wr_word))
		else $error("read does not return last write");
	a_port_write_pin: assert property (port_we |=> pin == $past(port_val))
		else $error("port write did not set pin");
	c_pwm_match: cover property (pwm_on && hit && mode[1]);

endmodule
`default_nettype wire

// ### core/tmr16_timer.sv
// 16-bit timer with byte access, two compares, capture and pwm
`timescale 1ns/100ps
`default_nettype none
`include "tmr16_defines.svh"

module tmr16_timer #(
	parameter int W  = 16, // counter width
	parameter int PW = 10  // pwm compare bits
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	// cpu byte register port
	input  wire logic [7:0]  io_addr,
	input  wire logic [7:0]  io_wdata,
	input  wire logic        io_we,
	input  wire logic        io_re,
	output logic      [7:0]  io_rdata,
	// control fields
	input  wire logic [2:0]  clock_select,
	input  wire logic        timer_tick,
	input  wire logic [1:0]  pwm_resolution,
	input  wire logic [1:0]  output_mode_a,
	input  wire logic [1:0]  output_mode_b,
	input  wire logic        capture_edge_select,
	// pins and port bits
	input  wire logic        capture_input_pin,
	input  wire logic        port_bit_for_output_a_we,
	input  wire logic        port_bit_for_output_a,
	input  wire logic        port_bit_for_output_b_we,
	input  wire logic        port_bit_for_output_b,
	output logic             compare_output_a,
	output logic             compare_output_b,
	// event flags toward the interrupt logic
	output logic             overflow_flag,
	output logic             compare_flag_a,
	output logic             compare_flag_b,
	output logic             capture_flag
);

	// ==========================================
	// decode helpers

	// top value for a resolution code
	function automatic logic [PW-1:0] top_of(input logic [1:0] res);
		case (res)
			`TMR_RES_8: top_of = `TMR_TOP_8;
			`TMR_RES_9: top_of = `TMR_TOP_9;
			default: top_of = `TMR_TOP_10;
		endcase
	endfunction

	// write strobe for one offset
	function automatic logic wr_at(input logic [7:0] a);
		wr_at = io_we && io_addr == a;
	endfunction

	// read strobe for one offset
	function automatic logic rd_at(input logic [7:0] a);
		rd_at = io_re && !io_we && io_addr == a;
	endfunction

	// ==========================================
	// state
	tmr16_pkg::byte_t       latch_q, latch_d;   // shared staging byte
	tmr16_pkg::byte_t       rdata_q, rdata_d;   // read data
	logic [W-1:0]           cnt_q, cnt_d;       // count register
	tmr16_pkg::count_dir_e  dir_q, dir_d;       // pwm direction
	logic                   counted_q, counted_d;
	logic                   up_q, up_d;         // last move upward
	logic                   ovf_q, ovf_d;
	logic                   pwm_on;
	logic                   run;
	logic [PW-1:0]          top;
	logic [W-1:0]           top_w;
	logic [W-1:0]           wr_word;
	logic [W-1:0]           cmp_a_val;
	logic [W-1:0]           cmp_b_val;
	logic [W-1:0]           cap_val;
	logic                   at_top;
	logic                   wr_cmpa_lo;         // compare a low-byte write
	logic                   wr_cmpb_lo;         // compare b low-byte write

	assign pwm_on = pwm_resolution != `TMR_RES_OFF;
	assign run = timer_tick && clock_select != `TMR_CS_STOP;
	assign top = top_of(pwm_resolution);
	assign top_w = {{(W-PW){1'b0}}, top};
	assign wr_word = {latch_q, io_wdata};
	assign at_top = pwm_on && counted_q && cnt_q[PW-1:0] == top;
	// low-byte strobes decoded in always_comb, so the channels see every bus change
	always_comb
	begin
		wr_cmpa_lo = wr_at(`TMR_OFS_CMPA_LO);
		wr_cmpb_lo = wr_at(`TMR_OFS_CMPB_LO);
	end

	// ==========================================
	// counter next value
	always_comb
	begin
		cnt_d = cnt_q;
		dir_d = dir_q;
		counted_d = 1'b0;
		up_d = up_q;
		ovf_d = 1'b0;
		if (wr_at(`TMR_OFS_CNT_LO))
			// preset: both bytes at once, no match this cycle
			cnt_d = wr_word;
		else if (run)
		begin
			counted_d = 1'b1;
			if (!pwm_on)
			begin
				// plain up-count, overflow on wrap
				cnt_d = cnt_q + 1'b1;
				up_d = 1'b1;
				ovf_d = cnt_q == '1;
			end
			else if (dir_q == tmr16_pkg::DIR_UP && cnt_q >= top_w)
			begin
				// turn around at top
				dir_d = tmr16_pkg::DIR_DOWN;
				cnt_d = cnt_q - 1'b1;
				up_d = 1'b0;
			end
			else if (dir_q == tmr16_pkg::DIR_UP || cnt_q == '0)
			begin
				// rising; leaving zero flags overflow
				dir_d = tmr16_pkg::DIR_UP;
				cnt_d = cnt_q + 1'b1;
				up_d = 1'b1;
				ovf_d = cnt_q == '0;
			end
			else
			begin
				// falling toward zero
				cnt_d = cnt_q - 1'b1;
				up_d = 1'b0;
			end
		end
	end

	// counter registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_q <= `TMR_RST_WORD;
			dir_q <= tmr16_pkg::DIR_UP;
			counted_q <= 1'b0;
			up_q <= 1'b1;
			ovf_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			dir_q <= dir_d;
			counted_q <= counted_d;
			up_q <= up_d;
			ovf_q <= ovf_d;
		end
	end

	// ==========================================
	// staging latch and read data
	always_comb
	begin
		latch_d = latch_q;
		rdata_d = rdata_q;
		// high-byte writes only stage
		if (wr_at(`TMR_OFS_CNT_HI) || wr_at(`TMR_OFS_CMPA_HI)
			|| wr_at(`TMR_OFS_CMPB_HI))
			latch_d = io_wdata;
		if (io_re && !io_we)
		begin
			case (io_addr)
				`TMR_OFS_CNT_LO:
				begin
					rdata_d = cnt_q[7:0];
					latch_d = cnt_q[15:8];
				end
				`TMR_OFS_CAP_LO:
				begin
					rdata_d = cap_val[7:0];
					latch_d = cap_val[15:8];
				end
				`TMR_OFS_CNT_HI: rdata_d = latch_q;
				`TMR_OFS_CAP_HI: rdata_d = latch_q;
				`TMR_OFS_CMPA_LO: rdata_d = cmp_a_val[7:0];
				`TMR_OFS_CMPA_HI: rdata_d = cmp_a_val[15:8];
				`TMR_OFS_CMPB_LO: rdata_d = cmp_b_val[7:0];
				`TMR_OFS_CMPB_HI: rdata_d = cmp_b_val[15:8];
				default: rdata_d = `TMR_RST_BYTE;
			endcase
		end
	end

	// latch and read registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			latch_q <= `TMR_RST_BYTE;
			rdata_q <= `TMR_RST_BYTE;
		end
		else
		begin
			latch_q <= latch_d;
			rdata_q <= rdata_d;
		end
	end

	assign io_rdata = rdata_q;
	assign overflow_flag = ovf_q;

	// ==========================================
	// compare channels
	tmr16_compare #(
		.W  (W),
		.PW (PW)
	) u_cmp_a (
		.clk        (clk),
		.rst_n      (rst_n),
		.pwm_on     (pwm_on),
		.wr_lo      (wr_cmpa_lo),
		.wr_word    (wr_word),
		.cnt        (cnt_q),
		.counted    (counted_q),
		.moved_up   (up_q),
		.at_top     (at_top),
		.top        (top),
		.div1       (clock_select == `TMR_CS_DIV1),
		.mode       (output_mode_a),
		.port_we    (port_bit_for_output_a_we),
		.port_val   (port_bit_for_output_a),
		.read_value (cmp_a_val),
		.match_flag (compare_flag_a),
		.pin        (compare_output_a)
	);

	tmr16_compare #(
		.W  (W),
		.PW (PW)
	) u_cmp_b (
		.clk        (clk),
		.rst_n      (rst_n),
		.pwm_on     (pwm_on),
		.wr_lo      (wr_cmpb_lo),
		.wr_word    (wr_word),
		.cnt        (cnt_q),
		.counted    (counted_q),
		.moved_up   (up_q),
		.at_top     (at_top),
		.top        (top),
		.div1       (clock_select == `TMR_CS_DIV1),
		.mode       (output_mode_b),
		.port_we    (port_bit_for_output_b_we),
		.port_val   (port_bit_for_output_b),
		.read_value (cmp_b_val),
		.match_flag (compare_flag_b),
		.pin        (compare_output_b)
	);

	// ==========================================
	// capture unit
	tmr16_capture #(
		.W (W)
	) u_cap (
		.clk                 (clk),
		.rst_n               (rst_n),
		.capture_input_pin   (capture_input_pin),
		.capture_edge_select (capture_edge_select),
		.cnt                 (cnt_q),
		.capture_register    (cap_val),
		.capture_flag        (capture_flag)
	);

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_count_low_load: assert property (wr_at(`TMR_OFS_CNT_LO)
		|=> cnt_q == {$past(latch_q), $past(io_wdata)})
		else $error("low write did not load full count");
	a_high_write_stage: assert property ((io_we && io_addr == `TMR_OFS_CNT_HI)
		|=> latch_q == $past(io_wdata) && ($stable(cnt_q) || counted_q))
		else $error("high write not staged");
	a_low_read_latch: assert property (rd_at(`TMR_OFS_CNT_LO)
		|=> latch_q == $past(cnt_q[15:8]) && io_rdata == $past(cnt_q[7:0]))
		else $error("low read did not latch high byte");
	a_cap_read_pair: assert property (rd_at(`TMR_OFS_CAP_LO) ##1 (!io_we && !io_re)
		##1 rd_at(`TMR_OFS_CAP_HI) |=> io_rdata == $past(cap_val[15:8], 3))
		else $error("capture high read not from latch");
	a_stop_holds: assert property ((clock_select == `TMR_CS_STOP
		&& !(io_we && io_addr == `TMR_OFS_CNT_LO)) |=> $stable(cnt_q))
		else $error("stopped timer moved");
	a_pwm_turn_top: assert property ((pwm_on && run && dir_q == tmr16_pkg::DIR_UP
		&& cnt_q == top_w && !io_we) |=> dir_q == tmr16_pkg::DIR_DOWN)
		else $error("pwm did not turn at top");
	a_pwm_ovf_zero: assert property ((pwm_on && overflow_flag)
		|-> $past(cnt_q) == '0 || !$past(pwm_on))
		else $error("pwm overflow not from zero");
	c_pwm_top: cover property (at_top);
	c_count_preset: cover property (wr_at(`TMR_OFS_CNT_LO) ##1 counted_q);

endmodule
`default_nettype wire

// ### test/tmr16_cpu_model.sv
// cpu model that drives the byte-wide timer register port
`timescale 1ns/100ps
`default_nettype none

module tmr16_cpu_model (
	input  wire logic       clk,
	output logic      [7:0] io_addr,
	output logic      [7:0] io_wdata,
	output logic            io_we,
	output logic            io_re,
	input  wire logic [7:0] io_rdata
);
	// ==========================================
	// idle bus
	initial
	begin
		io_addr = 8'h00;
		io_wdata = 8'h00;
		io_we = 1'b0;
		io_re = 1'b0;
	end

	// ==========================================
	// byte cycles, launched at the falling edge
	// one write; data inverted afterwards so a stale byte never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_we = 1'b1;
		@(negedge clk);
		io_we = 1'b0;
		io_wdata = ~d;
	endtask

	// one read; the byte is registered, valid one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		io_addr = a;
		io_re = 1'b1;
		@(negedge clk);
		io_re = 1'b0;
		d = io_rdata;
	endtask

	// ==========================================
	// word cycles; each pair ends before another starts
	// high byte first, low byte commits
	task automatic wr16(input logic [7:0] lo_a, input logic [15:0] d);
		wr(lo_a + 8'h01, d[15:8]);
		wr(lo_a, d[7:0]);
	endtask

	// low byte first; count and capture high bytes come from the latch, compare high bytes are read directly
	task automatic rd16(input logic [7:0] lo_a, output logic [15:0] d);
		rd(lo_a, d[7:0]);
		rd(lo_a + 8'h01, d[15:8]);
	endtask
endmodule

`default_nettype wire

// ### test/tmr16_timer_test.sv
// self-checking bench of the 16-bit timer
`timescale 1ns/100ps
`default_nettype none
`include "tmr16_defines.svh"

module tmr16_timer_test;
	// ==========================================
	// signals
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  io_addr;
	logic [7:0]  io_wdata;
	logic        io_we;
	logic        io_re;
	logic [7:0]  io_rdata;
	logic [2:0]  clock_select = `TMR_CS_STOP;
	logic        timer_tick = 1'b0;
	logic [1:0]  pwm_resolution = `TMR_RES_OFF;
	logic [1:0]  output_mode_a = `TMR_COM_OFF;
	logic [1:0]  output_mode_b = `TMR_COM_OFF;
	logic        capture_edge_select = 1'b1;
	logic        capture_input_pin = 1'b0;
	logic        pa_we = 1'b0;
	logic        pa = 1'b0;
	logic        pb_we = 1'b0;
	logic        pb = 1'b0;
	logic        out_a;
	logic        out_b;
	logic        ovf;
	logic        flag_a;
	logic        flag_b;
	logic        cap_flag;
	logic [15:0] w;
	int          err_total = 0;
	int          checked = 0;

	// ==========================================
	// clock, design and cpu
	always #5 clk = ~clk;

	tmr16_timer dut (
		.clk                      (clk),
		.rst_n                    (rst_n),
		.io_addr                  (io_addr),
		.io_wdata                 (io_wdata),
		.io_we                    (io_we),
		.io_re                    (io_re),
		.io_rdata                 (io_rdata),
		.clock_select             (clock_select),
		.timer_tick               (timer_tick),
		.pwm_resolution           (pwm_resolution),
		.output_mode_a            (output_mode_a),
		.output_mode_b            (output_mode_b),
		.capture_edge_select      (capture_edge_select),
		.capture_input_pin        (capture_input_pin),
		.port_bit_for_output_a_we (pa_we),
		.port_bit_for_output_a    (pa),
		.port_bit_for_output_b_we (pb_we),
		.port_bit_for_output_b    (pb),
		.compare_output_a         (out_a),
		.compare_output_b         (out_b),
		.overflow_flag            (ovf),
		.compare_flag_a           (flag_a),
		.compare_flag_b           (flag_b),
		.capture_flag             (cap_flag)
	);

	tmr16_cpu_model cpu (
		.clk      (clk),
		.io_addr  (io_addr),
		.io_wdata (io_wdata),
		.io_we    (io_we),
		.io_re    (io_re),
		.io_rdata (io_rdata)
	);

	// ==========================================
	// helpers
	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// one timer tick; returns at the falling edge after the stepping edge
	task automatic tick1();
		@(negedge clk);
		timer_tick = 1'b1;
		@(negedge clk);
		timer_tick = 1'b0;
	endtask

	// counts capture pulses over four cycles after a pin change
	task automatic cap_edge(input logic lvl, input logic [15:0] exp_n);
		int n;
		n = 0;
		@(negedge clk);
		capture_input_pin = lvl;
		repeat (4)
		begin
			@(negedge clk);
			n += int'(cap_flag === 1'b1);
		end
		chk(16'(n), exp_n, "capture pulses");
	endtask

	// ==========================================
	// scenarios
	// reset values of every register
	task automatic t_reset();
		cpu.rd16(`TMR_OFS_CAP_LO, w);
		chk(w, `TMR_RST_WORD, "capture reset");
		cpu.rd16(`TMR_OFS_CMPA_LO, w);
		chk(w, `TMR_RST_WORD, "compare a reset");
		cpu.rd16(`TMR_OFS_CMPB_LO, w);
		chk(w, `TMR_RST_WORD, "compare b reset");
		cpu.rd16(`TMR_OFS_CNT_LO, w);
		chk(w, `TMR_RST_WORD, "count reset");
		$display("test reset values done");
	endtask

	// count and compare word access, read-only capture
	task automatic t_access();
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h1234);
		cpu.rd16(`TMR_OFS_CNT_LO, w);
		chk(w, 16'h1234, "count word");
		cpu.wr16(`TMR_OFS_CMPA_LO, 16'hA5C3);
		cpu.rd16(`TMR_OFS_CMPA_LO, w);
		chk(w, 16'hA5C3, "compare a word");
		cpu.wr(`TMR_OFS_CAP_LO, 8'h5A);
		cpu.rd16(`TMR_OFS_CAP_LO, w);
		chk(w, `TMR_RST_WORD, "capture write ignored");
		$display("test register access done");
	endtask

	// matches by counting in every normal output mode, none by preset
	task automatic t_match();
		logic [1:0] m[4] = '{`TMR_COM_TOGGLE, `TMR_COM_CLEAR, `TMR_COM_SET, `TMR_COM_OFF};
		logic       p[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
		clock_select = `TMR_CS_DIV1;
		cpu.wr16(`TMR_OFS_CMPA_LO, 16'h0010);
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h0010);
		repeat (2) @(negedge clk);
		chk(16'(flag_a), 16'h0000, "match by preset");
		foreach (m[i])
		begin
			output_mode_a = m[i];
			cpu.wr16(`TMR_OFS_CNT_LO, 16'h000F);
			tick1();
			@(negedge clk);
			chk(16'(flag_a), 16'h0001, "match flag");
			chk(16'(out_a), 16'(p[i]), "match pin");
		end
		cpu.rd16(`TMR_OFS_CNT_LO, w);
		chk(w, 16'h0010, "count after preset");
		$display("test compare match done");
	endtask

	// port bits set the compare outputs
	task automatic t_port();
		@(negedge clk);
		pa_we = 1'b1;
		pb_we = 1'b1;
		pb = 1'b1;
		@(negedge clk);
		pa_we = 1'b0;
		pb_we = 1'b0;
		chk({out_a, out_b}, 16'h0001, "port bits");
		$display("test port bits done");
	endtask

	// capture on the selected edge only
	task automatic t_capture();
		clock_select = `TMR_CS_STOP;
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h0777);
		cap_edge(1'b1, 16'h0001);
		cpu.rd16(`TMR_OFS_CAP_LO, w);
		chk(w, 16'h0777, "capture rising");
		capture_edge_select = 1'b0;
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h0888);
		cap_edge(1'b0, 16'h0001);
		cap_edge(1'b1, 16'h0000);
		cpu.rd16(`TMR_OFS_CAP_LO, w);
		chk(w, 16'h0888, "capture falling");
		$display("test capture done");
	endtask

	// wrap overflow, pwm overflow, turn at top, holding copy
	task automatic t_pwm();
		clock_select = `TMR_CS_DIV1;
		cpu.wr16(`TMR_OFS_CNT_LO, 16'hFFFF);
		tick1();
		chk(16'(ovf), 16'h0001, "wrap overflow");
		pwm_resolution = `TMR_RES_8;
		tick1();
		chk(16'(ovf), 16'h0001, "pwm overflow");
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h00FE);
		tick1();
		tick1();
		cpu.rd16(`TMR_OFS_CNT_LO, w);
		chk(w, 16'h00FE, "turn at top");
		cpu.wr16(`TMR_OFS_CMPB_LO, 16'h0080);
		cpu.rd16(`TMR_OFS_CMPB_LO, w);
		chk(w, 16'h0080, "holding copy");
		$display("test pwm done");
	endtask

	// pwm output b: zero match, holding copy taken at top, down matches
	task automatic t_pwm_out();
		output_mode_b = `TMR_COM_CLEAR;
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h0081);
		tick1();
		@(negedge clk);
		chk(16'(flag_b), 16'h0000, "no match before top");
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h0001);
		tick1();
		@(negedge clk);
		chk(16'(flag_b), 16'h0001, "zero match flag");
		chk(16'(out_b), 16'h0000, "zero compare low");
		tick1();
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h00FE);
		tick1();
		tick1();
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h0081);
		tick1();
		@(negedge clk);
		chk(16'(flag_b), 16'h0001, "pwm match flag");
		chk(16'(out_b), 16'h0001, "non-inverted down match");
		output_mode_b = `TMR_COM_SET;
		cpu.wr16(`TMR_OFS_CNT_LO, 16'h0081);
		tick1();
		@(negedge clk);
		chk(16'(out_b), 16'h0000, "inverted down match");
		$display("test pwm outputs done");
	endtask

	// ==========================================
	// verdict
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog far beyond the expected few hundred cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		err_total++;
		test_done();
	end

	// main sequence
	initial
	begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_access();
		t_match();
		t_port();
		t_capture();
		t_pwm();
		t_pwm_out();
		test_done();
	end
endmodule

`default_nettype wire
